// ---- hdl/bcd_pkg.sv ----
// Package with constants and carrier types for the branch and condition decoder.
package bcd_pkg;
   localparam int unsigned BCD_COND_MSB = 31;
   localparam int unsigned BCD_COND_LSB = 28;
   localparam logic [3:0] BCD_COND_EQ = 4'h0;
   localparam logic [3:0] BCD_COND_NE = 4'h1;
   localparam logic [3:0] BCD_COND_CS = 4'h2;
   localparam logic [3:0] BCD_COND_CC = 4'h3;
   localparam logic [3:0] BCD_COND_MI = 4'h4;
   localparam logic [3:0] BCD_COND_PL = 4'h5;
   localparam logic [3:0] BCD_COND_VS = 4'h6;
   localparam logic [3:0] BCD_COND_VC = 4'h7;
   localparam logic [3:0] BCD_COND_HI = 4'h8;
   localparam logic [3:0] BCD_COND_LS = 4'h9;
   localparam logic [3:0] BCD_COND_GE = 4'ha;
   localparam logic [3:0] BCD_COND_LT = 4'hb;
   localparam logic [3:0] BCD_COND_GT = 4'hc;
   localparam logic [3:0] BCD_COND_LE = 4'hd;
   localparam logic [3:0] BCD_COND_ALWAYS = 4'he;
   localparam logic [3:0] BCD_COND_RESERVED = 4'hf;
   // Exchange encoding: bits 27:4 fixed, register index in 3:0.
   localparam logic [23:0] BCD_BX_PATTERN = 24'h12fff1;
   // Plain and linking branch: bits 27:25 = 101, bit 24 = link.
   localparam logic [2:0] BCD_BR_PATTERN = 3'h5;
   localparam int unsigned BCD_LINK_BIT = 24;
   localparam logic [31:0] BCD_PC_AHEAD = 32'h0000_0008;
   localparam logic [31:0] BCD_WORD = 32'h0000_0004;
   localparam logic [3:0] BCD_PC_INDEX = 4'hf;
   // Two sequential plus one non-sequential cycle.
   localparam logic [1:0] BCD_BRANCH_CYCLES = 2'h3;
   localparam logic [31:0] BCD_RESET_PC = 32'h0000_0000;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } bcd_flags_t;

   typedef enum logic [1:0] {
      BCD_IDLE,
      BCD_BUSY
   } bcd_state_t;

   typedef struct packed {
      bcd_state_t state;
      logic [1:0] cycle;
      logic [31:0] pc;
      logic compact;
      logic redirect;
      logic flush;
      logic link_we;
      logic [31:0] link_data;
      logic executed;
   } bcd_regs_t;
endpackage

// ---- hdl/bcd_cond_eval.sv ----
// Condition field evaluator against the status flags.
`timescale 1ns/1ps
`default_nettype none
module bcd_cond_eval
   import bcd_pkg::*;
(
   input wire logic [3:0] cond_i,
   input wire bcd_flags_t flags_i,
   output logic pass_o
);
   always_comb
   begin
      pass_o = 1'b0;
      case (cond_i)
         BCD_COND_EQ: pass_o = flags_i.z;
         BCD_COND_NE: pass_o = ~flags_i.z;
         BCD_COND_CS: pass_o = flags_i.c;
         BCD_COND_CC: pass_o = ~flags_i.c;
         BCD_COND_MI: pass_o = flags_i.n;
         BCD_COND_PL: pass_o = ~flags_i.n;
         BCD_COND_VS: pass_o = flags_i.v;
         BCD_COND_VC: pass_o = ~flags_i.v;
         BCD_COND_HI: pass_o = flags_i.c & ~flags_i.z;
         BCD_COND_LS: pass_o = ~flags_i.c | flags_i.z;
         BCD_COND_GE: pass_o = flags_i.n == flags_i.v;
         BCD_COND_LT: pass_o = flags_i.n != flags_i.v;
         BCD_COND_GT: pass_o = ~flags_i.z & (flags_i.n == flags_i.v);
         BCD_COND_LE: pass_o = flags_i.z | (flags_i.n != flags_i.v);
         BCD_COND_ALWAYS: pass_o = 1'b1;
         // The reserved code never executes, so a stray one is harmless.
         default: pass_o = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- hdl/bcd_branch_decoder.sv ----
// Decode-stage condition check and branch execution unit.
// Summary of operation
// - Condition comes from bits 31:28; failing instructions act as no-operations.
// - Codes 0000 to 0111 test Z, C, N, V set then clear.
// - Code 1000 needs C set, Z clear; 1001 needs C clear or Z set.
// - 1010 needs N equal V, 1011 N differ V, 1100 Z clear and N equal V.
// - Code 1101 passes when Z set or N differs from V.
// - Code 1110 always executes regardless of flags.
// - Exchange branch loads PC from source register; bit 0 selects compact state.
// - A taken exchange branch flushes the pipeline and refetches from target.
// - An exchange branch completes in two sequential plus one non-sequential cycle.
// - Branch offset is 24 bits, shifted by two, sign-extended, added to PC.
// - Branch base is instruction address plus eight bytes.
// - Linking branch writes next instruction address, low bits clear, to link register.
// - Plain and linking branches take two sequential plus one extra cycle.
`timescale 1ns/1ps
`default_nettype none
module bcd_branch_decoder
   import bcd_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic INSTR_VALID_I,
   input wire logic [31:0] INSTR_I,
   input wire logic [31:0] INSTR_ADDR_I,
   input wire bcd_flags_t FLAGS_I,
   input wire logic [31:0] SOURCE_REGISTER_I,
   output logic [3:0] SOURCE_INDEX_O,
   output logic INSTR_READY_O,
   output logic EXECUTE_O,
   output logic REDIRECT_O,
   output logic [31:0] TARGET_O,
   output logic FLUSH_O,
   output logic COMPACT_O,
   output logic LINK_WE_O,
   output logic [31:0] LINK_DATA_O
);
   bcd_regs_t r;
   bcd_regs_t next_r;
   logic cond_pass;
   logic is_bx;
   logic is_br;
   logic take;
   logic [31:0] pc_base;
   logic [31:0] offset;

   bcd_cond_eval u_cond (
      .cond_i(INSTR_I[BCD_COND_MSB:BCD_COND_LSB]),
      .flags_i(FLAGS_I),
      .pass_o(cond_pass)
   );

   assign SOURCE_INDEX_O = INSTR_I[3:0];
   assign is_bx = INSTR_I[27:4] == BCD_BX_PATTERN;
   assign is_br = INSTR_I[27:25] == BCD_BR_PATTERN;
   assign pc_base = INSTR_ADDR_I + BCD_PC_AHEAD;
   assign offset = {{6{INSTR_I[23]}}, INSTR_I[23:0], 2'b00};
   // Only the idle state accepts; later instructions wait while a branch drains.
   assign INSTR_READY_O = r.state == BCD_IDLE;
   assign take = INSTR_VALID_I & INSTR_READY_O & cond_pass & (is_bx | is_br);

   always_comb
   begin
      next_r = r;
      next_r.redirect = 1'b0;
      next_r.flush = 1'b0;
      next_r.link_we = 1'b0;
      next_r.executed = INSTR_VALID_I & INSTR_READY_O & cond_pass;
      case (r.state)
         BCD_IDLE:
         begin
            // A failing branch changes nothing and does not flush.
            if (take)
            begin
               next_r.state = BCD_BUSY;
               next_r.cycle = BCD_BRANCH_CYCLES - 2'h1;
               next_r.redirect = 1'b1;
               next_r.flush = 1'b1;
               if (is_bx)
               begin
                  next_r.pc = SOURCE_REGISTER_I;
                  next_r.compact = SOURCE_REGISTER_I[0];
               end
               else
               begin
                  next_r.pc = pc_base + offset;
                  if (INSTR_I[BCD_LINK_BIT])
                  begin
                     next_r.link_we = 1'b1;
                     next_r.link_data = (INSTR_ADDR_I + BCD_WORD) & ~32'h0000_0003;
                  end
               end
            end
         end
         // The fetch unit refills during these cycles, so later instructions are held off.
         BCD_BUSY:
         begin
            next_r.cycle = r.cycle - 2'h1;
            if (r.cycle == 2'h1)
            begin
               next_r.state = BCD_IDLE;
            end
         end
         default: next_r.state = BCD_IDLE;
      endcase
   end

   // One register update per clock keeps every pulse output clean for the fetch unit.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         r <= '{state: BCD_IDLE, cycle: 2'h0, pc: BCD_RESET_PC, compact: 1'b0, redirect: 1'b0,
                flush: 1'b0, link_we: 1'b0, link_data: 32'h0000_0000, executed: 1'b0};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign EXECUTE_O = r.executed;
   assign REDIRECT_O = r.redirect;
   assign TARGET_O = r.pc;
   assign FLUSH_O = r.flush;
   assign COMPACT_O = r.compact;
   assign LINK_WE_O = r.link_we;
   assign LINK_DATA_O = r.link_data;

   property p_cond_gate;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_VALID_I && INSTR_READY_O && !cond_pass) |=> !REDIRECT_O && !LINK_WE_O && !EXECUTE_O;
   endproperty
   a_cond_gate: assert property (p_cond_gate) else $error("Failed condition still acted.");

   property p_always;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_I[31:28] == BCD_COND_ALWAYS) |-> cond_pass;
   endproperty
   a_always: assert property (p_always) else $error("Always condition did not pass.");

   property p_ge_lt;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_I[31:29] == 3'h5) |-> cond_pass == ((FLAGS_I.n == FLAGS_I.v) ^ INSTR_I[28]);
   endproperty
   a_ge_lt: assert property (p_ge_lt) else $error("Signed compare condition wrong.");

   property p_bx_target;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && is_bx) |=> REDIRECT_O && FLUSH_O && TARGET_O == $past(SOURCE_REGISTER_I)
         && COMPACT_O == $past(SOURCE_REGISTER_I[0]);
   endproperty
   a_bx_target: assert property (p_bx_target) else $error("Exchange target or state wrong.");

   property p_br_target;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && is_br) |=> TARGET_O == $past(INSTR_ADDR_I) + 32'h8
         + {{6{$past(INSTR_I[23])}}, $past(INSTR_I[23:0]), 2'b00};
   endproperty
   a_br_target: assert property (p_br_target) else $error("Branch target wrong.");

   property p_link;
      @(posedge CLK_I) disable iff (RESET_I)
      (take && is_br && INSTR_I[24]) |=> LINK_WE_O && LINK_DATA_O[1:0] == 2'b00
         && LINK_DATA_O[31:2] == $past(INSTR_ADDR_I[31:2]) + 30'h1;
   endproperty
   a_link: assert property (p_link) else $error("Link value wrong.");

   property p_cycles;
      @(posedge CLK_I) disable iff (RESET_I)
      take |=> !INSTR_READY_O [*2] ##1 INSTR_READY_O;
   endproperty
   a_cycles: assert property (p_cycles) else $error("Branch did not take three cycles.");

   property p_no_flush;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_VALID_I && INSTR_READY_O && !take) |=> !FLUSH_O && $stable(TARGET_O) && $stable(COMPACT_O);
   endproperty
   a_no_flush: assert property (p_no_flush) else $error("Untaken instruction changed state.");

   property p_single_flag;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_I[31] == 1'b0) |-> cond_pass == (INSTR_I[28] ^ ((INSTR_I[30:29] == 2'h0) ? FLAGS_I.z
         : (INSTR_I[30:29] == 2'h1) ? FLAGS_I.c : (INSTR_I[30:29] == 2'h2) ? FLAGS_I.n : FLAGS_I.v));
   endproperty
   a_single_flag: assert property (p_single_flag) else $error("Single flag condition wrong.");

   property p_hi_ls;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_I[31:29] == 3'h4) |-> cond_pass == ((FLAGS_I.c & ~FLAGS_I.z) ^ INSTR_I[28]);
   endproperty
   a_hi_ls: assert property (p_hi_ls) else $error("Unsigned compare condition wrong.");

   property p_gt_le;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_I[31:29] == 3'h6) |-> cond_pass == ((~FLAGS_I.z & (FLAGS_I.n == FLAGS_I.v)) ^ INSTR_I[28]);
   endproperty
   a_gt_le: assert property (p_gt_le) else $error("Greater or less-equal condition wrong.");

   property p_flush_pulse;
      @(posedge CLK_I) disable iff (RESET_I)
      FLUSH_O |-> REDIRECT_O ##1 (!FLUSH_O && !REDIRECT_O);
   endproperty
   a_flush_pulse: assert property (p_flush_pulse) else $error("Flush was not a single pulse with redirect.");

   property p_busy_quiet;
      @(posedge CLK_I) disable iff (RESET_I)
      (INSTR_VALID_I && !INSTR_READY_O) |=> !EXECUTE_O && !REDIRECT_O && !LINK_WE_O;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("Instruction behind a taken branch acted.");

   c_bx: cover property (@(posedge CLK_I) take && is_bx && SOURCE_REGISTER_I[0]);
   c_stall: cover property (@(posedge CLK_I) INSTR_VALID_I && !INSTR_READY_O);
   c_bl: cover property (@(posedge CLK_I) take && is_br && INSTR_I[24]);
   c_fail: cover property (@(posedge CLK_I) INSTR_VALID_I && is_br && !cond_pass);
endmodule
`default_nettype wire

// ---- verification/bcd_regfile_model.sv ----
// Register file model that answers source register reads for the decoder.
`timescale 1ns/1ps
`default_nettype none
module bcd_regfile_model
   import bcd_pkg::*;
(
   input wire logic [3:0] index_i,
   input wire logic [31:0] base_i,
   output logic [31:0] data_o
);
   // Read in the same cycle; exchange branches never name index 15 since its outcome is undefined.
   assign data_o = base_i ^ {8{index_i}};
endmodule
`default_nettype wire

// ---- verification/branch_condition_decoder_tb.sv ----
// Self-checking testbench for the branch and condition decoder.
`timescale 1ns/1ps
`default_nettype none
module branch_condition_decoder_tb
   import bcd_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic [31:0] instr = 32'h0;
   logic [31:0] addr = 32'h0;
   bcd_flags_t flags = '0;
   logic [31:0] base = 32'h0;
   logic [3:0] src_idx;
   logic [31:0] src_val, target, link_data;
   logic ready, execute, redirect, flush, compact, link_we;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [31:0] seed = 32'd33427;

   bcd_regfile_model bcd_regfile_model_i (.index_i(src_idx), .base_i(base), .data_o(src_val));
   bcd_branch_decoder bcd_branch_decoder_i (.CLK_I(clk), .RESET_I(rst), .INSTR_VALID_I(valid), .INSTR_I(instr),
      .INSTR_ADDR_I(addr), .FLAGS_I(flags), .SOURCE_REGISTER_I(src_val), .SOURCE_INDEX_O(src_idx),
      .INSTR_READY_O(ready), .EXECUTE_O(execute), .REDIRECT_O(redirect), .TARGET_O(target), .FLUSH_O(flush),
      .COMPACT_O(compact), .LINK_WE_O(link_we), .LINK_DATA_O(link_data));

   initial
   begin
      forever #5 clk = ~clk;
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function logic cond_ok(input logic [3:0] c, input bcd_flags_t f);
      logic [15:0] t;
      t = {1'b0, 1'b1, f.z | (f.n ^ f.v), ~f.z & ~(f.n ^ f.v), f.n ^ f.v, ~(f.n ^ f.v), ~f.c | f.z, f.c & ~f.z,
         ~f.v, f.v, ~f.n, f.n, ~f.c, f.c, ~f.z, f.z};
      return t[c];
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task stop_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // The ceiling leaves ample slack over 300 instructions of at most three cycles each.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         stop_test();
      end
   end

   initial
   begin
      logic [31:0] r, exp_tgt, exp_link, exp_src;
      logic [23:0] off;
      logic [3:0] cond;
      logic exp_comp, pass, is_bx, is_br, taken;
      int stall, exp_stall;
      exp_tgt = 32'h0;
      exp_comp = 1'b0;
      exp_stall = 0;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      chk(32'(ready), 32'h1);
      chk(target, BCD_RESET_PC);
      chk(32'(compact), 32'h0);
      for (int i = 0; i < 300; i++)
      begin
         // A second reset in mid-run, taken once any branch has drained, must clear state and pulses.
         if (i == 150)
         begin
            valid = 1'b0;
            while (ready !== 1'b1)
            begin
               @(posedge clk);
               #1;
            end
            rst = 1'b1;
            @(posedge clk);
            #1 rst = 1'b0;
            chk(32'(ready), 32'h1);
            chk(target, BCD_RESET_PC);
            chk(32'({compact, redirect, flush, link_we, execute}), 32'h0);
            exp_tgt = BCD_RESET_PC;
            exp_comp = 1'b0;
            exp_stall = 0;
         end
         r = rnd();
         flags = bcd_flags_t'(r[3:0]);
         base = rnd();
         addr = rnd() & 32'hffff_fffc;
         cond = (i < 3) ? BCD_COND_ALWAYS : 4'(i % 15);
         off = (i == 1) ? 24'h800000 : (i == 2) ? 24'h7fffff : r[31:8];
         if (r[5:4] == 2'h1 || i < 3)
            instr = {cond, BCD_BR_PATTERN, r[6], off};
         else if (r[5:4] == 2'h0)
            instr = {cond, BCD_BX_PATTERN, 4'(r[11:8] % 15)};
         else
            instr = {cond, 3'h1, r[28:4]};
         valid = 1'b1;
         stall = 0;
         while (ready !== 1'b1 && stall < 8)
         begin
            @(posedge clk);
            #1;
            stall++;
         end
         chk(stall, exp_stall);
         pass = cond_ok(cond, flags);
         is_bx = instr[27:4] == BCD_BX_PATTERN;
         is_br = instr[27:25] == BCD_BR_PATTERN;
         taken = pass & (is_bx | is_br);
         exp_src = base ^ {8{instr[3:0]}};
         if (taken && is_bx)
         begin
            exp_tgt = exp_src;
            exp_comp = exp_src[0];
         end
         if (taken && is_br)
            exp_tgt = addr + BCD_PC_AHEAD + {{6{instr[23]}}, instr[23:0], 2'b00};
         exp_link = (addr + BCD_WORD) & 32'hffff_fffc;
         @(posedge clk);
         #1;
         chk(32'(execute), 32'(pass));
         chk(32'(redirect), 32'(taken));
         chk(32'(flush), 32'(taken));
         chk(target, exp_tgt);
         chk(32'(compact), 32'(exp_comp));
         chk(32'(link_we), 32'(taken & is_br & instr[24]));
         if (taken && is_br && instr[24])
            chk(link_data, exp_link);
         exp_stall = taken ? 2 : 0;
      end
      stop_test();
   end
endmodule
`default_nettype wire
